// [piso_shift_register_8bit.sv]
// Eight-stage parallel-in, serial-out shift register with a word buffer in front.
// Assumes all inputs are synchronous to core_clk; the gated clock pins are sampled
// and their rising edge is detected inside this clock domain.
`timescale 1ns/1ps
`include "piso_cfg.svh"
module piso_shift_register_8bit #(
    parameter int STAGES     = `PISO_STAGES,
    parameter int FIFO_DEPTH = `PISO_FIFO_DEPTH
) (
    // System clock and reset.
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Gated shift clock pins; either may serve as clock or as enable.
    input  wire logic              shift_clock,
    input  wire logic              clock_enable_n,
    // Stage controls.
    input  wire logic              parallel_load_n,
    input  wire logic              serial_in,
    input  wire logic              master_clear_n,
    // Parallel word stream into the buffer.
    input  wire logic              word_valid,
    output      logic              word_ready,
    input  wire logic [STAGES-1:0] par_word,
    // Serial output.
    output      logic              last_stage_out
);
    initial begin
        if (STAGES != `PISO_STAGES) begin
            $error("piso_shift_register_8bit supports exactly eight stages");
        end
    end

    word_stream_if #(.WIDTH(STAGES)) buf_out ();

    word_fifo #(
        .WIDTH (STAGES),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .in_valid (word_valid),
        .in_ready (word_ready),
        .in_data  (par_word),
        .out      (buf_out.source)
    );

    logic [STAGES-1:0]    stages;
    logic                 eff_clk_q;
    logic [STAGES-1:0]    next_stages;
    piso_pkg::stage_op_t  op;

    // The effective clock is the OR of both pins, so they are interchangeable.
    wire eff_clk  = shift_clock | clock_enable_n;
    wire eff_rise = eff_clk && !eff_clk_q;
    // A load waits for a word; while the buffer is empty the edge is skipped.
    wire load_ok  = !parallel_load_n && buf_out.valid;
    wire do_load  = eff_rise && load_ok;
    wire do_shift = eff_rise && parallel_load_n;

    assign buf_out.ready = do_load && master_clear_n;
    assign op = do_shift ? piso_pkg::OP_SHIFT : piso_pkg::OP_HOLD;

    // Next stage contents: parallel word by index, or a shift toward the last stage.
    always_comb begin
        next_stages = stages;
        if (do_load) begin
            next_stages = buf_out.data;
        end else begin
            case (op)
                piso_pkg::OP_SHIFT: begin
                    next_stages = {stages[STAGES-2:0], serial_in};
                end
                piso_pkg::OP_HOLD: begin
                    next_stages = stages;
                end
                default: begin
                    next_stages = stages;
                end
            endcase
        end
    end

    // Edge detector history for the effective clock.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            eff_clk_q <= 1'b1;
        end else begin
            eff_clk_q <= eff_clk;
        end
    end

    // Stage register; master clear overrides load and shift, taking hold at the next core_clk rise.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stages <= `PISO_CLEAR_VALUE;
        end else if (!master_clear_n) begin
            stages <= `PISO_CLEAR_VALUE;
        end else begin
            stages <= next_stages;
        end
    end

    // Only the last stage leaves the block; it is masked while clear is low.
    assign last_stage_out = stages[STAGES-1] & master_clear_n;
endmodule

// [piso_cfg.svh]
// Constants for the eight-stage parallel-in, serial-out shift register.
// Assumes it is included by its bare name from the design files.
`ifndef PISO_CFG_SVH
`define PISO_CFG_SVH

`define PISO_STAGES      8
`define PISO_CLEAR_VALUE 8'h00
`define PISO_FIFO_DEPTH  16

`endif

// [piso_pkg.sv]
// Types for the shift register, which uses only stage_op_t; its word buffer uses none of them.
// Assumes piso_cfg.svh sits in the include path.
`include "piso_cfg.svh"
package piso_pkg;
    typedef logic [`PISO_STAGES-1:0] stage_word_t;
    typedef enum logic [1:0] {
        OP_HOLD  = 2'b01,
        OP_SHIFT = 2'b10
    } stage_op_t;
endpackage

// [word_stream_if.sv]
// Valid/ready word stream between the buffer and the shift register.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// [word_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides.
// Assumes a single clock and an asynchronous active-high reset.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Filling side.
    input  wire logic             in_valid,
    output      logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    word_stream_if.source         out
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("word_fifo depth must be a power of two, at least 2");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic [WIDTH-1:0] head;

    // Full and empty come straight from the pointer difference.
    wire full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push  = in_valid && !full;
    wire pop   = out.ready && !empty;

    assign in_ready  = !full;
    assign out.valid = !empty;
    assign out.data  = head;

    // Storage is written only by a push.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Head word is read from the flip-flop storage at the read pointer.
    always_comb begin
        head = mem[rd_ptr[AW-1:0]];
    end

    // Pointer updates.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// [piso_sva.sv]
// Port assertions for the shift register.
// Assumes one clock domain; bound to the top module.
`timescale 1ns/1ps
module piso_sva #(parameter int STAGES = 8) (
    input wire logic core_clk, rst, shift_clock, clock_enable_n, parallel_load_n,
    input wire logic master_clear_n, word_valid, word_ready, last_stage_out
);
    logic prev, pclr;
    wire rise = (shift_clock | clock_enable_n) & !prev;
    wire live = master_clear_n & pclr;
    wire ld_edge = rise & !parallel_load_n & master_clear_n;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Past levels of the gated clock and of the clear.
    always_ff @(posedge core_clk or posedge rst)
        if (rst) {prev, pclr} <= 2'h3;
        else {prev, pclr} <= {shift_clock | clock_enable_n, master_clear_n};
    chk_clear_low: assert property (!master_clear_n |-> !last_stage_out)
        else $error("output high in clear");
    chk_clear_held: assert property (!pclr |-> !last_stage_out)
        else $error("stage not cleared");
    chk_rise_only: assert property ($changed(last_stage_out) && live |-> $past(rise))
        else $error("output moved without rise");
    chk_enable_gates: assert property (clock_enable_n[*3] ##0 live |-> $stable(last_stage_out))
        else $error("enable did not gate");
    chk_clock_gates: assert property (shift_clock[*3] ##0 live |-> $stable(last_stage_out))
        else $error("clock pin did not gate");
    chk_reset_state: assert property ($past(rst) |-> word_ready && !last_stage_out)
        else $error("bad state after reset");
    chk_fill_push: assert property ($fell(word_ready) |-> $past(word_valid))
        else $error("full without a push");
    chk_pop_on_load: assert property ($rose(word_ready) |-> $past(ld_edge))
        else $error("word freed without load");
endmodule
bind piso_shift_register_8bit piso_sva #(.STAGES(STAGES)) chk (.*);

// [serial_sink.sv]
// Downstream stage taking the register's output on each shifting rise.
// Assumes the same pins and clock domain as the register.
`timescale 1ns/1ps
module serial_sink (
    input  wire logic core_clk, rst, eff, shifting, din,
    output logic      got, bit_seen
);
    logic prev;
    // The bit before the edge is taken, as a cascaded stage would.
    always_ff @(posedge core_clk or posedge rst)
        if (rst) {prev, got} <= 2'h2;
        else {prev, got, bit_seen} <= {eff, eff & !prev & shifting, din};
endmodule

// [piso_shift_register_8bit_bench.sv]
// Self-checking bench with a downstream stage as receiver.
// Assumes the design files and serial_sink are compiled first.
`timescale 1ns/1ps
module piso_shift_register_8bit_bench;
    logic core_clk = 0, rst = 1, sc = 1, ce_n = 0, ld_n = 1, si = 0, cl_n = 1, wv = 0, wr, so, got, bs;
    logic [7:0] w = 8'h00, m = 8'h00, wq[$];
    logic eq[$];
    int n_errors = 0, n_tests = 0;
    piso_shift_register_8bit DUT (.core_clk, .rst, .shift_clock(sc), .clock_enable_n(ce_n), .parallel_load_n(ld_n),
        .serial_in(si), .master_clear_n(cl_n), .word_valid(wv), .word_ready(wr), .par_word(w), .last_stage_out(so));
    serial_sink sink (.core_clk, .rst, .eff(sc | ce_n), .shifting(ld_n), .din(so), .got, .bit_seen(bs));
    initial forever #50 core_clk = ~core_clk;
    task automatic chk(string what, logic [7:0] e, logic [7:0] s);
        n_tests++;
        if (s !== e) begin n_errors++; $display("MISMATCH %s expected %h seen %h", what, e, s); end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // One step: k 0 pulses the clock pin, 1 the enable pin, 2 is gated off.
    task automatic step(int k, logic ld, logic s);
        {ld_n, si} = {ld, s};
        if (k < 2 && !ld) m = wq.pop_front();
        if (k < 2 && ld) eq.push_back(m[7]);
        if (k < 2 && ld) m = {m[6:0], s};
        ce_n = k == 2;
        @(negedge core_clk) sc = 0;
        if (k == 1) @(negedge core_clk) ce_n = 1;
        @(negedge core_clk) sc = 1;
        @(negedge core_clk) ce_n = 0;
        @(negedge core_clk);
    endtask
    // Each captured bit is compared with the oldest noted one.
    always @(negedge core_clk) if (got === 1'h1) chk("serial bit", eq.size() ? eq.pop_front() : 8'hFF, bs);
    initial begin
        #500000;
        n_errors++;
        close_out;
    end
    initial begin
        void'($urandom(35));
        repeat (12) @(negedge core_clk);
        {rst, wv} = 2'h1;
        repeat (17) begin
            w = $urandom;
            if (wq.size() < 16) wq.push_back(w);
            @(negedge core_clk);
        end
        wv = 0;
        chk("ready full", 0, wr);
        $display("fill done");
        for (int i = 0; i < 16; i++) begin
            step($urandom % 2, 0, 0);
            repeat ($urandom % 9 + 1) step($urandom % 3, 1, $urandom % 2);
            if (i == 5) begin
                cl_n = 0;
                #1 chk("clear out", 0, so);
                @(negedge core_clk) cl_n = 1;
                m = 8'h00;
            end
        end
        repeat (8) step(0, 1, 0);
        chk("ready empty", 1, wr);
        chk("bits left", 0, eq.size());
        $display("stream done");
        close_out;
    end
endmodule
